/* File: rtl/hpt_pkg.sv */
// Constants and types shared by the hashed page table search logic
package hpt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Address and hash geometry
  localparam int ADDR_W         = 64;
  localparam int HASH_W         = 39;
  // 32-bit variant: 19-bit hash, 10 low bits direct, 9 masked, 16-bit origin
  localparam int H32_W          = 19;
  localparam int H32_LOW_W      = 10;
  localparam int MASK32_W       = 9;
  localparam int ORG32_W        = 16;
  localparam int GRP32_ZERO_W   = 6;
  localparam int VAR32_ADDR_W   = 32;
  // 64-bit variant: 39-bit hash, 11 low bits direct, 28 masked, 46-bit origin
  localparam int H64_LOW_W      = 11;
  localparam int MASK64_W       = 28;
  localparam int ORG64_W        = 46;
  localparam int GRP64_ZERO_W   = 7;
  localparam int SIZE_CODE_W    = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Entry group layout
  localparam int SLOT_W         = 3;
  localparam logic [SLOT_W-1:0] FIRST_SLOT = 3'h0;
  localparam logic [SLOT_W-1:0] LAST_SLOT  = 3'h7;
  // log2 of entry size in bytes: 8 bytes narrow, 16 bytes wide
  localparam int ENTRY_SHIFT_32 = 3;
  localparam int ENTRY_SHIFT_64 = 4;

  ////////////////////////////////////////////////////////////////////////////
  // APB register map
  localparam int APB_AW         = 8;
  localparam int DATA_W         = 32;
  localparam logic [APB_AW-1:0] CTRL_OFS      = 8'h00;
  localparam logic [APB_AW-1:0] ORIGIN_LO_OFS = 8'h04;
  localparam logic [APB_AW-1:0] ORIGIN_HI_OFS = 8'h08;
  localparam logic [APB_AW-1:0] STATUS_OFS    = 8'h0C;
  localparam logic [APB_AW-1:0] COUNT_OFS     = 8'h10;
  // Control fields
  localparam int CTRL_VAR_BIT   = 0;
  localparam int CTRL_SIZE_LSB  = 8;
  localparam int CTRL_MASK_LSB  = 16;
  localparam int ORIGIN_HI_W    = 14;
  // Status fields
  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_HIT_BIT     = 1;
  localparam int ST_FAULT_BIT   = 2;
  localparam int ST_SEC_BIT     = 3;
  localparam int ST_SLOT_LSB    = 4;
  // Counters
  localparam int CNT_W          = 16;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  // Reset values
  localparam logic [DATA_W-1:0]  DATA_ZERO   = 32'h0000_0000;
  localparam logic [ADDR_W-1:0]  ADDR_ZERO   = 64'h0000_0000_0000_0000;
  localparam logic [ORG64_W-1:0] ORIGIN_RST  = 46'h0000_0000_0000;
  localparam logic [SIZE_CODE_W-1:0] SIZE_RST = 5'h00;
  localparam logic [MASK32_W-1:0] MASK_RST   = 9'h000;
  localparam logic [CNT_W-1:0]   CNT_RST     = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Search sequencer states
  typedef enum logic [0:0] {
    st_idle,
    st_read
  } search_state_e;

endpackage

/* File: rtl/hpt_group_addr.sv */
// Entry group physical address generator for both table variants
`timescale 1ns/10ps
module hpt_group_addr (
  // Table configuration
  input  wire logic                             variant_64,
  input  wire logic [hpt_pkg::ORG64_W-1:0]      origin,
  input  wire logic [hpt_pkg::SIZE_CODE_W-1:0]  size_code,
  input  wire logic [hpt_pkg::MASK32_W-1:0]     size_mask,
  // Hash value for this group
  input  wire logic [hpt_pkg::HASH_W-1:0]       hash,
  // Address of entry 0 of the group
  output logic      [hpt_pkg::ADDR_W-1:0]       group_addr
);

  logic [hpt_pkg::MASK64_W-1:0]     mask64;
  logic [hpt_pkg::VAR32_ADDR_W-1:0] addr32;
  logic [hpt_pkg::ADDR_W-1:0]       addr64;

  // Size code gives the count of hash bits let through; codes past 28 saturate
  assign mask64 = ~({hpt_pkg::MASK64_W{1'b1}} << size_code);

  assign addr32 = {origin[hpt_pkg::ORG32_W-1:hpt_pkg::MASK32_W],
                   origin[hpt_pkg::MASK32_W-1:0]
                   | (hash[hpt_pkg::H32_W-1:hpt_pkg::H32_LOW_W] & size_mask),
                   hash[hpt_pkg::H32_LOW_W-1:0],
                   {hpt_pkg::GRP32_ZERO_W{1'b0}}};

  // Masked origin bits are expected zero; the OR would corrupt them otherwise
  assign addr64 = {origin[hpt_pkg::ORG64_W-1:hpt_pkg::MASK64_W],
                   origin[hpt_pkg::MASK64_W-1:0]
                   | (hash[hpt_pkg::HASH_W-1:hpt_pkg::H64_LOW_W] & mask64),
                   hash[hpt_pkg::H64_LOW_W-1:0],
                   {hpt_pkg::GRP64_ZERO_W{1'b0}}};

  assign group_addr = variant_64 ? addr64
                    : {{(hpt_pkg::ADDR_W-hpt_pkg::VAR32_ADDR_W){1'b0}}, addr32};

endmodule // hpt_group_addr

/* File: rtl/hpt_search.sv */
// Hashed page table search engine with APB configuration and status
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
module hpt_search #(
  parameter int SEG_ID_W   = 52,
  parameter int PAGE_IDX_W = 6,
  parameter int PAGE_NUM_W = 52,
  parameter int ATTR_W = 4,
  parameter int PG_W   = 2
) (
  // Clock, reset, enable
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  input  wire logic                            ce,
  // APB slave
  input  wire logic [hpt_pkg::APB_AW-1:0]      paddr,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [hpt_pkg::DATA_W-1:0]      pwdata,
  output logic      [hpt_pkg::DATA_W-1:0]      prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  // Search request
  input  wire logic                            req_valid,
  output logic                                 req_ready,
  input  wire logic [SEG_ID_W-1:0]             req_segment_id,
  input  wire logic [PAGE_IDX_W-1:0]           req_page_index,
  input  wire logic [hpt_pkg::HASH_W-1:0]      req_hash,
  // Table memory read port
  output logic                                 mem_req,
  output logic      [hpt_pkg::ADDR_W-1:0]      mem_addr,
  input  wire logic                            mem_ack,
  input  wire logic [SEG_ID_W-1:0]             rsp_segment_id,
  input  wire logic [PAGE_IDX_W-1:0]           rsp_page_index,
  input  wire logic                            rsp_in_use,
  input  wire logic                            rsp_secondary,
  input  wire logic [PAGE_NUM_W-1:0]           rsp_page_number,
  input  wire logic [ATTR_W-1:0]               rsp_attr,
  input  wire logic [PG_W-1:0]                 rsp_guard,
  input  wire logic                            rsp_touched,
  input  wire logic                            rsp_modified,
  // Search result
  output logic                                 done,
  output logic                                 hit,
  output logic                                 fault,
  output logic      [PAGE_NUM_W-1:0]           res_page_number,
  output logic      [ATTR_W-1:0]               res_attr,
  output logic      [PG_W-1:0]                 res_guard,
  output logic                                 res_touched,
  output logic                                 res_modified,
  output logic                                 res_secondary,
  output logic      [hpt_pkg::SLOT_W-1:0]      res_slot,
  output logic      [hpt_pkg::ADDR_W-1:0]      res_addr
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    hpt_pkg::search_state_e            st;
    logic [hpt_pkg::SLOT_W-1:0]        slot;
    logic                              secondary;
    logic [SEG_ID_W-1:0]               segment_id;
    logic [PAGE_IDX_W-1:0]             page_index;
    logic [hpt_pkg::HASH_W-1:0]        hash;
    logic                              req_ready;
    logic                              mem_req;
    logic [hpt_pkg::ADDR_W-1:0]        mem_addr;
    logic                              done;
    logic                              hit;
    logic                              fault;
    logic [PAGE_NUM_W-1:0]             page_number;
    logic [ATTR_W-1:0]                 attr;
    logic [PG_W-1:0]                   guard;
    logic                              touched;
    logic                              modified;
    logic                              res_secondary;
    logic [hpt_pkg::SLOT_W-1:0]        res_slot;
    logic [hpt_pkg::ADDR_W-1:0]        res_addr;
    logic                              variant_64;
    logic [hpt_pkg::SIZE_CODE_W-1:0]   size_code;
    logic [hpt_pkg::MASK32_W-1:0]      size_mask;
    logic [hpt_pkg::ORG64_W-1:0]       origin;
    logic [hpt_pkg::CNT_W-1:0]         hit_count;
    logic [hpt_pkg::CNT_W-1:0]         fault_count;
    logic                              pready;
    logic                              pslverr;
    logic [hpt_pkg::DATA_W-1:0]        prdata;
  } state_s;

  state_s s;
  state_s next_s;

  logic [hpt_pkg::ADDR_W-1:0] prim_addr;
  logic [hpt_pkg::ADDR_W-1:0] sec_addr;
  logic [hpt_pkg::ADDR_W-1:0] slot_ofs;
  logic                       entry_match;

  ////////////////////////////////////////////////////////////////////////////
  // Group address generators, fed from the next state so mem_addr is ready
  // in the cycle the read is issued

  hpt_group_addr u_prim (
    .variant_64 (next_s.variant_64),
    .origin     (next_s.origin),
    .size_code  (next_s.size_code),
    .size_mask  (next_s.size_mask),
    .hash       (next_s.hash),
    .group_addr (prim_addr)
  );

  hpt_group_addr u_sec (
    .variant_64 (next_s.variant_64),
    .origin     (next_s.origin),
    .size_code  (next_s.size_code),
    .size_mask  (next_s.size_mask),
    .hash       (~next_s.hash),
    .group_addr (sec_addr)
  );

  // Group flag in the entry identifies its placement, not the physical group
  assign entry_match = rsp_in_use
                     && (rsp_segment_id == s.segment_id) && (rsp_page_index == s.page_index)
                     && (rsp_secondary == s.secondary);

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_s   = s;
    slot_ofs = hpt_pkg::ADDR_ZERO;
    if (ce) begin
      next_s.done    = 1'b0;
      next_s.pready  = 1'b0;
      next_s.pslverr = 1'b0;

      // APB: one wait state, answer registered in the access phase
      if (psel && penable && !s.pready) begin
        next_s.pready = 1'b1;
        next_s.prdata = hpt_pkg::DATA_ZERO;
        case (paddr)
          hpt_pkg::CTRL_OFS: begin
            if (pwrite) begin
              next_s.variant_64 = pwdata[hpt_pkg::CTRL_VAR_BIT];
              next_s.size_code  = pwdata[hpt_pkg::CTRL_SIZE_LSB +: hpt_pkg::SIZE_CODE_W];
              next_s.size_mask  = pwdata[hpt_pkg::CTRL_MASK_LSB +: hpt_pkg::MASK32_W];
            end else begin
              next_s.prdata[hpt_pkg::CTRL_VAR_BIT]                          = s.variant_64;
              next_s.prdata[hpt_pkg::CTRL_SIZE_LSB +: hpt_pkg::SIZE_CODE_W] = s.size_code;
              next_s.prdata[hpt_pkg::CTRL_MASK_LSB +: hpt_pkg::MASK32_W]    = s.size_mask;
            end
          end
          hpt_pkg::ORIGIN_LO_OFS: begin
            if (pwrite) begin
              next_s.origin[hpt_pkg::DATA_W-1:0] = pwdata;
            end else begin
              next_s.prdata = s.origin[hpt_pkg::DATA_W-1:0];
            end
          end
          hpt_pkg::ORIGIN_HI_OFS: begin
            if (pwrite) begin
              next_s.origin[hpt_pkg::ORG64_W-1:hpt_pkg::DATA_W] = pwdata[hpt_pkg::ORIGIN_HI_W-1:0];
            end else begin
              next_s.prdata[hpt_pkg::ORIGIN_HI_W-1:0] = s.origin[hpt_pkg::ORG64_W-1:hpt_pkg::DATA_W];
            end
          end
          hpt_pkg::STATUS_OFS: begin
            next_s.prdata[hpt_pkg::ST_BUSY_BIT]                    = (s.st == hpt_pkg::st_read);
            next_s.prdata[hpt_pkg::ST_HIT_BIT]                     = s.hit;
            next_s.prdata[hpt_pkg::ST_FAULT_BIT]                   = s.fault;
            next_s.prdata[hpt_pkg::ST_SEC_BIT]                     = s.res_secondary;
            next_s.prdata[hpt_pkg::ST_SLOT_LSB +: hpt_pkg::SLOT_W] = s.res_slot;
          end
          hpt_pkg::COUNT_OFS: begin
            next_s.prdata = {s.hit_count, s.fault_count};
          end
          default: begin
            next_s.pslverr = 1'b1;
          end
        endcase
      end

      // Search sequencer
      unique case (s.st)
        hpt_pkg::st_idle: begin
          if (req_valid && s.req_ready) begin
            next_s.st        = hpt_pkg::st_read;
            next_s.segment_id = req_segment_id;
            next_s.page_index = req_page_index;
            next_s.hash      = req_hash;
            next_s.slot      = hpt_pkg::FIRST_SLOT;
            next_s.secondary = 1'b0;
            next_s.req_ready = 1'b0;
            next_s.mem_req   = 1'b1;
          end
        end
        hpt_pkg::st_read: begin
          if (mem_ack) begin
            if (entry_match) begin
              // First match wins; flags follow the chosen entry
              next_s.st            = hpt_pkg::st_idle;
              next_s.mem_req       = 1'b0;
              next_s.req_ready     = 1'b1;
              next_s.done          = 1'b1;
              next_s.hit           = 1'b1;
              next_s.fault         = 1'b0;
              next_s.page_number   = rsp_page_number;
              next_s.attr          = rsp_attr;
              next_s.guard         = rsp_guard;
              next_s.touched       = rsp_touched;
              next_s.modified      = rsp_modified;
              next_s.res_secondary = s.secondary;
              next_s.res_slot      = s.slot;
              next_s.res_addr      = s.mem_addr;
              next_s.hit_count     = s.hit_count + hpt_pkg::CNT_ONE;
            end else if (s.slot != hpt_pkg::LAST_SLOT) begin
              // Ascending scan suits tables filled from slot zero
              next_s.slot = s.slot + hpt_pkg::SLOT_W'(1);
            end else if (!s.secondary) begin
              next_s.secondary = 1'b1;
              next_s.slot      = hpt_pkg::FIRST_SLOT;
            end else begin
              next_s.st            = hpt_pkg::st_idle;
              next_s.mem_req       = 1'b0;
              next_s.req_ready     = 1'b1;
              next_s.done          = 1'b1;
              next_s.hit           = 1'b0;
              next_s.fault         = 1'b1;
              next_s.res_secondary = s.secondary;
              next_s.res_slot      = s.slot;
              next_s.res_addr      = s.mem_addr;
              next_s.fault_count   = s.fault_count + hpt_pkg::CNT_ONE;
            end
          end
        end
      endcase

      // Entry offset sits in bits cleared by the group address
      if (next_s.variant_64) begin
        slot_ofs = hpt_pkg::ADDR_W'(next_s.slot) << hpt_pkg::ENTRY_SHIFT_64;
      end else begin
        slot_ofs = hpt_pkg::ADDR_W'(next_s.slot) << hpt_pkg::ENTRY_SHIFT_32;
      end
      // Config writes during a search retarget the remaining reads
      next_s.mem_addr = (next_s.secondary ? sec_addr : prim_addr) | slot_ofs;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{st: hpt_pkg::st_idle, slot: hpt_pkg::FIRST_SLOT, req_ready: 1'b1,
             mem_addr: hpt_pkg::ADDR_ZERO, res_addr: hpt_pkg::ADDR_ZERO,
             origin: hpt_pkg::ORIGIN_RST, size_code: hpt_pkg::SIZE_RST,
             size_mask: hpt_pkg::MASK_RST, hit_count: hpt_pkg::CNT_RST,
             fault_count: hpt_pkg::CNT_RST, prdata: hpt_pkg::DATA_ZERO, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign prdata        = s.prdata;
  assign pready        = s.pready;
  assign pslverr       = s.pslverr;
  assign req_ready     = s.req_ready;
  assign mem_req       = s.mem_req;
  assign mem_addr      = s.mem_addr;
  assign done          = s.done;
  assign hit           = s.hit;
  assign fault         = s.fault;
  assign res_page_number = s.page_number;
  assign res_attr      = s.attr;
  assign res_guard     = s.guard;
  assign res_touched   = s.touched;
  assign res_modified  = s.modified;
  assign res_secondary = s.res_secondary;
  assign res_slot      = s.res_slot;
  assign res_addr      = s.res_addr;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  done_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.done && ce) |=> !s.done)
    else $error("done held past one enabled cycle");

  done_kind_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.done |-> (s.hit ^ s.fault))
    else $error("done without exactly one of hit and fault");

  fault_last_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.done && s.fault) |-> (s.res_secondary && (s.res_slot == hpt_pkg::LAST_SLOT)))
    else $error("fault before both groups were scanned");

  hit_fields_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.done && s.hit && $past(ce)) |->
      ($past(rsp_in_use) && ($past(rsp_segment_id) == $past(s.segment_id))
       && ($past(rsp_page_index) == $past(s.page_index))))
    else $error("hit on entry with wrong fields or not in use");

  hit_group_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.done && s.hit && $past(ce)) |-> ($past(rsp_secondary) == s.res_secondary))
    else $error("hit on entry with wrong group flag");

  wide_align_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.mem_req && s.variant_64) |->
      ((s.mem_addr[hpt_pkg::GRP64_ZERO_W-1:hpt_pkg::ENTRY_SHIFT_64] == s.slot)
       && (s.mem_addr[hpt_pkg::ENTRY_SHIFT_64-1:0] == '0)))
    else $error("wide entry address not slot aligned");

  narrow_align_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.mem_req && !s.variant_64) |->
      ((s.mem_addr[hpt_pkg::ADDR_W-1:hpt_pkg::VAR32_ADDR_W] == '0)
       && (s.mem_addr[hpt_pkg::GRP32_ZERO_W-1:hpt_pkg::ENTRY_SHIFT_32] == s.slot)
       && (s.mem_addr[hpt_pkg::ENTRY_SHIFT_32-1:0] == '0)))
    else $error("narrow entry address malformed");

  sec_compl_a: assert property (@(posedge pclk) disable iff (!presetn)
    next_s.variant_64
      ? (sec_addr[hpt_pkg::GRP64_ZERO_W +: hpt_pkg::H64_LOW_W]
         == ~prim_addr[hpt_pkg::GRP64_ZERO_W +: hpt_pkg::H64_LOW_W])
      : (sec_addr[hpt_pkg::GRP32_ZERO_W +: hpt_pkg::H32_LOW_W]
         == ~prim_addr[hpt_pkg::GRP32_ZERO_W +: hpt_pkg::H32_LOW_W]))
    else $error("secondary hash bits not complement of primary");

  base_form_a: assert property (@(posedge pclk) disable iff (!presetn)
    next_s.variant_64
      ? (prim_addr[hpt_pkg::ADDR_W-1:hpt_pkg::ADDR_W-hpt_pkg::ORG64_W+hpt_pkg::MASK64_W]
         == next_s.origin[hpt_pkg::ORG64_W-1:hpt_pkg::MASK64_W])
      : (prim_addr[hpt_pkg::VAR32_ADDR_W-1:hpt_pkg::GRP32_ZERO_W+hpt_pkg::H32_LOW_W]
         == (next_s.origin[hpt_pkg::ORG32_W-1:0]
             | {{(hpt_pkg::ORG32_W-hpt_pkg::MASK32_W){1'b0}},
                next_s.hash[hpt_pkg::H32_W-1:hpt_pkg::H32_LOW_W] & next_s.size_mask})))
    else $error("group base does not follow origin and mask");

  stop_on_hit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.done && s.hit) |-> (!s.mem_req && s.req_ready))
    else $error("scan continued after a hit");

  sec_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(s.secondary) && $past(ce)) |->
      $past(mem_ack && (s.slot == hpt_pkg::LAST_SLOT) && !entry_match)) 
    else $error("secondary group entered before primary missed");

endmodule // hpt_search

/* File: tb/hpt_mem_model.sv */
// Table memory model answering entry reads in order
`timescale 1ns/10ps
module hpt_mem_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Entry read port
  input  wire logic        mem_req,
  input  wire logic [63:0] mem_addr,
  output logic             mem_ack,
  output logic [31:0]      rsp
);
  logic [31:0] ent [16];
  logic [63:0] seen [16];
  int          n;
  int          seed = 81;
  // Inverted outside ack so stale fields never pass for valid ones
  assign rsp = mem_ack ? ent[n[3:0]] : ~ent[n[3:0]];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
    end else begin
      if (mem_ack && mem_req) begin
        seen[n[3:0]] <= mem_addr;
        n <= n + 1;
      end
      mem_ack <= mem_req && !mem_ack && ($random(seed) % 3 != 0);
    end
  end
endmodule // hpt_mem_model

/* File: tb/testbench.sv */
// Random and corner searches of the page table engine
`timescale 1ns/10ps
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, req_valid, pready, pslverr, req_ready;
  logic        mem_req, mem_ack, done, hit, fault, res_secondary, res_touched, res_modified, w, err;
  logic [7:0]  paddr, req_segment_id, res_page_number;
  logic [5:0]  req_page_index;
  logic [3:0]  res_attr;
  logic [1:0]  res_guard;
  logic [38:0] req_hash;
  logic [31:0] pwdata, prdata, rsp, rd, e;
  logic [63:0] mem_addr, res_addr;
  logic [2:0]  res_slot;
  logic [45:0] org;
  logic [27:0] m28;
  logic [8:0]  mk;
  logic [4:0]  sc;
  int          seed = 81, errors, checks_done, cyc, t, k, p, nd, c, nh, nf;
  int          dk[4] = '{0, 8, 14, 15};
  int          cp[5] = '{16, 0, 8, 7, 15};
  hpt_search #(.SEG_ID_W(8), .PAGE_NUM_W(8)) hpt_search_i (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req_ready(req_ready),
    .req_segment_id(req_segment_id), .req_page_index(req_page_index), .req_hash(req_hash),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .rsp_segment_id(rsp[7:0]),
    .rsp_page_index(rsp[13:8]), .rsp_in_use(rsp[14]), .rsp_secondary(rsp[15]), .rsp_page_number(rsp[23:16]),
    .rsp_attr(rsp[27:24]), .rsp_guard(rsp[29:28]), .rsp_touched(rsp[30]), .rsp_modified(rsp[31]),
    .done(done), .hit(hit), .fault(fault), .res_page_number(res_page_number), .res_attr(res_attr),
    .res_guard(res_guard), .res_touched(res_touched), .res_modified(res_modified),
    .res_secondary(res_secondary), .res_slot(res_slot), .res_addr(res_addr));
  hpt_mem_model hpt_mem_model_i (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_ack(mem_ack), .rsp(rsp));
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] x, input string m);
    checks_done++;
    if (g !== x) begin
      errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic [63:0] grp(input logic [38:0] h);
    if (w) return {org[45:28], org[27:0] | (h[38:11] & m28), h[10:0], 7'h00};
    return {32'h0000_0000, org[15:9], org[8:0] | (h[18:10] & mk), h[9:0], 6'h00};
  endfunction
  // Reads 0..7 primary group, 8..15 secondary group
  function automatic logic [63:0] ent_addr(input int q);
    return grp(q[3] ? ~req_hash : req_hash) + (64'(q[2:0]) << (w ? 4 : 3));
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    for (cyc = 0; cyc < 20000; cyc++) @(posedge pclk);
    errors++;
    test_done();
  end
  initial begin
    {presetn, psel, penable, pwrite, req_valid, paddr, pwdata, req_segment_id, req_page_index, req_hash} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk(err, 1'b1, "unmapped read");
    for (t = 0; t < 24; t++) begin
      w = $random(seed);
      // Codes past 28 included so saturation is reached
      sc = 5'($unsigned($random(seed)) % 32);
      m28 = 28'((64'h1 << sc) - 1);
      mk = 9'($random(seed));
      org = {$random(seed), $random(seed)};
      if (w) org[27:0] = org[27:0] & ~m28;
      else org[8:0] = org[8:0] & ~mk;
      {req_segment_id, req_page_index, req_hash} <= {$random(seed), $random(seed), $random(seed)};
      apb(1'b1, hpt_pkg::CTRL_OFS, {7'h00, mk, 3'h0, sc, 7'h00, w});
      apb(1'b1, hpt_pkg::ORIGIN_LO_OFS, org[31:0]);
      apb(1'b1, hpt_pkg::ORIGIN_HI_OFS, {18'h00000, org[45:32]});
      apb(1'b0, hpt_pkg::CTRL_OFS, 32'h0000_0000);
      chk(rd, {7'h00, mk, 3'h0, sc, 7'h00, w}, "ctrl readback");
      p = (t < 5) ? cp[t] : $unsigned($random(seed)) % 17;
      for (k = 0; k < 16; k++) begin
        e = $random(seed);
        e[15:0] = {k[3], 1'b1, req_page_index, req_segment_id};
        if (k != p) e = e ^ (32'h1 << dk[$unsigned($random(seed)) % 4]);
        hpt_mem_model_i.ent[k] = e;
      end
      hpt_mem_model_i.n <= 0;
      req_valid <= 1'b1;
      @(posedge pclk);
      req_valid <= 1'b0;
      nd = 0;
      for (c = 0; c < 300; c++) begin
        @(posedge pclk);
        #1;
        if (done === 1'b1) nd++;
      end
      chk(nd, 1, "done count");
      chk({req_ready, mem_req}, 2'b10, "idle after search");
      chk({hit, fault}, {p < 16, p == 16}, "outcome");
      chk(hpt_mem_model_i.n, (p < 16) ? p + 1 : 16, "read count");
      chk({res_secondary, res_slot}, (p < 16) ? p : 15, "slot");
      if (p < 16) chk({res_modified, res_touched, res_guard, res_attr, res_page_number},
        hpt_mem_model_i.ent[p][31:16], "entry fields");
      chk(res_addr, ent_addr((p < 16) ? p : 15), "result address");
      for (k = 0; k < hpt_mem_model_i.n; k++) chk(hpt_mem_model_i.seen[k], ent_addr(k), "entry address");
      if (p < 16) nh++;
      else nf++;
      apb(1'b0, hpt_pkg::STATUS_OFS, 32'h0000_0000);
      chk(rd[2:0], {p == 16, p < 16, 1'b0}, "status");
      $display("test %0d ends", t);
    end
    apb(1'b0, hpt_pkg::COUNT_OFS, 32'h0000_0000);
    chk(rd, {16'(nh), 16'(nf)}, "event counts");
    test_done();
  end
endmodule // testbench
